// [design/sew_slave.sv]
// Two-wire serial memory slave with page write and self-timed programming
`timescale 1ns/10ps
`include "sew_defines.svh"

// Behaviour
// - Every start is followed by an eight-bit address word deciding selection.
// - Respond only when upper four address bits hold the fixed device type.
// - Next three bits must equal the three chip select inputs.
// - An unconnected chip select input counts as low.
// - Lowest address bit one means read, zero means write.
// - Match drives acknowledge low; mismatch gives no acknowledge, back to idle.
// - Write protect high blocks all array programming.
// - Byte write: word address then one data byte, each acknowledged.
// - Stop after a write starts the self-timed programming cycle.
// - During programming bus inputs are ignored, no response given.
// - Page write accepts up to 63 more bytes, each acknowledged.
// - Writes increment only the low six address bits, wrapping inside page.
// - Polling address words are acknowledged only after programming ends.
// - Address counter holds last accessed address plus one, retained.
// - Read address wraps from last byte of memory to first.
// - Current read sends byte at counter; controller then nacks and stops.
// - Random read loads address by dummy write, then repeated start read.
// - Controller acknowledge during read advances to the next byte.
// - Data falling with clock high is start; rising is stop.
// - Ninth clock carries acknowledge driven low by the receiver.
// - Word address is fifteen bits for the larger capacity.
// - Standby after stop and finished operations, and at power-up.
module sew_slave
  import sew_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `SEW_PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclPin,
  input wire logic sdaIn,
  input wire logic chipSelectBit0,
  input wire logic chipSelectBit1,
  input wire logic chipSelectBit2,
  input wire logic writeProtect,
  output logic sdaOut,
  output logic sdaOe,
  output logic programBusy
);

  function automatic logic devMatch(input logic [7:0] word, input logic [2:0] cs);
    devMatch = (word[7:4] == `SEW_DEV_TYPE) && (word[3:1] == cs);
  endfunction : devMatch

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
  logic [2:0] csMeta, csSync;
  logic wpMeta, wpSync;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
      csMeta <= 3'h0;
      csSync <= 3'h0;
      wpMeta <= 1'b0;
      wpSync <= 1'b0;
    end else begin
      sclMeta <= sclPin;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
      // Floating strap pins read as low
      csMeta <= {chipSelectBit2 === 1'b1, chipSelectBit1 === 1'b1,
                 chipSelectBit0 === 1'b1};
      csSync <= csMeta;
      wpMeta <= (writeProtect === 1'b1);
      wpSync <= wpMeta;
    end
  end

  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise = sclSync & ~sclPrev;
  assign sclFall = ~sclSync & sclPrev;
  assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  sew_state_e state, next_state;
  sew_kind_e kind, next_kind;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shiftReg, next_shiftReg;
  logic [`SEW_ADDR_W-1:0] addr, next_addr;
  logic isRead, next_isRead, wrPending, next_wrPending;
  logic next_sdaOe, next_programBusy;
  logic [31:0] progCnt, next_progCnt;
  logic pushValid, maskClr, memWe, ackIt;
  logic [1:0] fifoCount;
  logic [7:0] mem [0:(1 << `SEW_ADDR_W)-1];
  logic [7:0] pageLatch [0:`SEW_PAGE_BYTES-1];
  logic [63:0] latchMask;
  logic [7:0] memRd;
  assign memRd = mem[addr];

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_bitCnt = bitCnt;
    next_shiftReg = shiftReg;
    next_addr = addr;
    next_isRead = isRead;
    next_wrPending = wrPending;
    next_sdaOe = sdaOe;
    next_progCnt = progCnt;
    pushValid = 1'b0;
    maskClr = 1'b0;
    memWe = 1'b0;
    ackIt = 1'b0;
    if (state == ST_PROG) begin
      // Bus is deaf while programming, so polling goes unanswered
      next_progCnt = progCnt + 32'h1;
      if (progCnt < 32'h40) begin
        memWe = latchMask[progCnt[5:0]];
      end
      if (progCnt == PROG_CYCLES - 1) begin
        next_state = ST_IDLE;
        next_progCnt = 32'h0;
        maskClr = 1'b1;
      end
    end else if (state == ST_WAITQ) begin
      // Let the last bytes reach the latch before the array is touched
      if (fifoCount == 2'h0) begin
        next_state = ST_PROG;
        next_wrPending = 1'b0;
      end
    end else if (startCond) begin
      next_state = ST_RX;
      next_kind = KIND_DEV;
      next_bitCnt = 4'h0;
      next_sdaOe = 1'b0;
    end else if (stopCond) begin
      next_sdaOe = 1'b0;
      if (wrPending && !wpSync) begin
        next_state = ST_WAITQ;
      end else begin
        next_state = ST_IDLE;
        next_wrPending = 1'b0;
      end
    end else begin
      unique case (state)
        ST_RX: begin
          if (sclRise) begin
            next_shiftReg = {shiftReg[6:0], sdaSync};
            next_bitCnt = bitCnt + 4'h1;
          end else if (sclFall && bitCnt == 4'h8) begin
            unique case (kind)
              KIND_DEV: begin
                ackIt = devMatch(shiftReg, csSync);
                next_isRead = shiftReg[0];
              end
              KIND_AHI: begin
                ackIt = 1'b1;
                next_addr = {shiftReg[6:0], addr[7:0]};
              end
              KIND_ALO: begin
                ackIt = 1'b1;
                next_addr = {addr[14:8], shiftReg};
                maskClr = 1'b1;
              end
              KIND_DATA: begin
                // A full buffer refuses the byte by withholding the acknowledge
                ackIt = (fifoCount != `SEW_FIFO_DEPTH);
                pushValid = ackIt;
                if (ackIt) begin
                  next_addr = {addr[14:6], addr[5:0] + 6'h01};
                  next_wrPending = 1'b1;
                end
              end
            endcase
            next_sdaOe = ackIt;
            next_state = ackIt ? ST_RX_ACK : ST_IDLE;
          end
        end
        ST_RX_ACK: begin
          if (sclFall) begin
            next_sdaOe = 1'b0;
            next_bitCnt = 4'h0;
            if (kind == KIND_DEV && isRead) begin
              next_shiftReg = memRd;
              next_addr = addr + 15'h0001;
              next_sdaOe = ~memRd[7];
              next_state = ST_TX;
            end else begin
              next_state = ST_RX;
              next_kind = (kind == KIND_DATA) ? KIND_DATA : sew_kind_e'(kind + 2'h1);
            end
          end
        end
        ST_TX: begin
          if (sclRise) begin
            next_bitCnt = bitCnt + 4'h1;
          end else if (sclFall) begin
            if (bitCnt == 4'h8) begin
              next_sdaOe = 1'b0;
              next_state = ST_TX_ACK;
            end else begin
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_sdaOe = ~shiftReg[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (sclRise && sdaSync) begin
            next_state = ST_IDLE;
          end else if (sclFall) begin
            next_shiftReg = memRd;
            next_addr = addr + 15'h0001;
            next_sdaOe = ~memRd[7];
            next_bitCnt = 4'h0;
            next_state = ST_TX;
          end
        end
        ST_IDLE, ST_WAITQ, ST_PROG: begin
        end
      endcase
    end
    next_programBusy = (next_state == ST_WAITQ) || (next_state == ST_PROG);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      kind <= KIND_DEV;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      addr <= 15'h0000;
      isRead <= 1'b0;
      wrPending <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      programBusy <= 1'b0;
      progCnt <= 32'h0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      addr <= next_addr;
      isRead <= next_isRead;
      wrPending <= next_wrPending;
      sdaOe <= next_sdaOe;
      sdaOut <= 1'b0;
      programBusy <= next_programBusy;
      progCnt <= next_progCnt;
    end
  end

  // ----------------------------------------
  // Two-entry write buffer and page latch
  // ----------------------------------------
  sew_wr_s fifoMem [0:1];
  logic wrPtr, rdPtr, next_wrPtr, next_rdPtr, popValid, popReady, pop;
  logic [1:0] next_fifoCount;
  logic [63:0] next_latchMask;
  assign popValid = (fifoCount != 2'h0);
  assign popReady = (state != ST_PROG); // Latch stalls while it is copied out
  assign pop = popValid & popReady;

  always_comb begin
    next_wrPtr = wrPtr ^ pushValid;
    next_rdPtr = rdPtr ^ pop;
    next_fifoCount = fifoCount + {1'b0, pushValid} - {1'b0, pop};
    next_latchMask = maskClr ? 64'h0 : latchMask;
    if (pop) begin
      next_latchMask = next_latchMask | (64'h1 << fifoMem[rdPtr].offset);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      fifoCount <= 2'h0;
      latchMask <= 64'h0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fifoCount <= next_fifoCount;
      latchMask <= next_latchMask;
    end
  end

  always_ff @(posedge core_clk) begin
    if (pushValid) begin
      fifoMem[wrPtr] <= '{offset: addr[5:0], data: shiftReg};
    end
    if (pop) begin
      pageLatch[fifoMem[rdPtr].offset] <= fifoMem[rdPtr].data;
    end
    if (memWe) begin
      mem[{addr[14:6], progCnt[5:0]}] <= pageLatch[progCnt[5:0]];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic devDecide;
  assign devDecide = (state == ST_RX) && (kind == KIND_DEV) && sclFall && (bitCnt == 4'h8)
                     && !startCond && !stopCond;

  sequence s_dataAck;
    (state == ST_RX) && (kind == KIND_DATA) && sclFall && (bitCnt == 4'h8)
      && !startCond && !stopCond && (fifoCount != 2'h2);
  endsequence
  sequence s_byteLoad;
    ((state == ST_TX_ACK) || (state == ST_RX_ACK && kind == KIND_DEV && isRead))
      && sclFall && !startCond && !stopCond && !(state == ST_TX_ACK && sclRise);
  endsequence

  property p_typeMismatch;
    @(posedge core_clk) disable iff (sys_rst)
    devDecide && (shiftReg[7:4] != `SEW_DEV_TYPE) |=> !sdaOe && state == ST_IDLE;
  endproperty
  a_typeMismatch: assert property (p_typeMismatch) else $error("type mismatch acked");
  property p_csMismatch;
    @(posedge core_clk) disable iff (sys_rst)
    devDecide && (shiftReg[3:1] != csSync) |=> !sdaOe ##1 !sdaOe;
  endproperty
  a_csMismatch: assert property (p_csMismatch) else $error("select mismatch acked");
  property p_matchAck;
    @(posedge core_clk) disable iff (sys_rst)
    devDecide && devMatch(shiftReg, csSync) |=> sdaOe && isRead == $past(shiftReg[0]);
  endproperty
  a_matchAck: assert property (p_matchAck) else $error("match not acked");
  property p_pageWrap;
    @(posedge core_clk) disable iff (sys_rst)
    s_dataAck |=> addr[14:6] == $past(addr[14:6]) && addr[5:0] == $past(addr[5:0]) + 6'h01;
  endproperty
  a_pageWrap: assert property (p_pageWrap) else $error("write address left page");
  property p_readWrap;
    @(posedge core_clk) disable iff (sys_rst)
    s_byteLoad and (addr == 15'h7FFF) |=> addr == 15'h0000 && state == ST_TX;
  endproperty
  a_readWrap: assert property (p_readWrap) else $error("read address did not wrap");
  property p_silentProg;
    @(posedge core_clk) disable iff (sys_rst)
    state == ST_PROG |-> !sdaOe && programBusy;
  endproperty
  a_silentProg: assert property (p_silentProg) else $error("bus driven while programming");
  property p_protectSkip;
    @(posedge core_clk) disable iff (sys_rst)
    stopCond && wpSync && state != ST_PROG && state != ST_WAITQ |=> state == ST_IDLE;
  endproperty
  a_protectSkip: assert property (p_protectSkip) else $error("protected write programmed");
  property p_stopProgram;
    @(posedge core_clk) disable iff (sys_rst)
    stopCond && wrPending && !wpSync && state != ST_PROG && state != ST_WAITQ
      |=> state == ST_WAITQ ##[1:4] state == ST_PROG;
  endproperty
  a_stopProgram: assert property (p_stopProgram) else $error("stop did not program");
  property p_progEnd;
    @(posedge core_clk) disable iff (sys_rst)
    state == ST_PROG && progCnt == PROG_CYCLES - 1 |=> state == ST_IDLE && !programBusy;
  endproperty
  a_progEnd: assert property (p_progEnd) else $error("programming did not end");
  property p_protectNoWrite;
    @(posedge core_clk) disable iff (sys_rst)
    memWe |-> $past(state) != ST_IDLE && state == ST_PROG;
  endproperty
  a_protectNoWrite: assert property (p_protectNoWrite) else $error("stray array write");

endmodule : sew_slave

// [pkg/sew_defines.svh]
// Constants of the two-wire serial memory slave
`ifndef SEW_DEFINES_SVH
`define SEW_DEFINES_SVH
`define SEW_DEV_TYPE 4'hA
`define SEW_ADDR_W 15
`define SEW_PAGE_BYTES 64
`define SEW_FIFO_DEPTH 2'h2
`define SEW_CLK_PERIOD_NS 4
`define SEW_PROG_TIME_MS 5
`define SEW_PROG_CYCLES ((`SEW_PROG_TIME_MS * 1000000) / `SEW_CLK_PERIOD_NS)
`endif

// [pkg/sew_pkg.sv]
// Types of the two-wire serial memory slave
package sew_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAITQ, ST_PROG
  } sew_state_e;
  typedef enum logic [1:0] {KIND_DEV, KIND_AHI, KIND_ALO, KIND_DATA} sew_kind_e;
  typedef struct packed {
    logic [5:0] offset;
    logic [7:0] data;
  } sew_wr_s;
endpackage : sew_pkg

// [tb/sew_ctl_model.sv]
// Bus controller model: drives the serial clock and pulls the data line low
`timescale 1ns/10ps
module sew_ctl_model (
  input wire logic core_clk,
  input wire logic sdaLine,
  output logic sclPin,
  output logic sdaLow
);
  // Clock stands high between frames, data released
  initial begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : tick

  // One bit of 12 core cycles; data moves only mid-low
  task automatic bitx(input logic b, output logic r);
    tick(3);
    sdaLow = ~b;
    tick(3);
    sclPin = 1'b1;
    tick(3);
    r = sdaLine;
    tick(3);
    sclPin = 1'b0;
  endtask : bitx

  task automatic start;
    tick(3);
    sdaLow = 1'b0;
    tick(3);
    sclPin = 1'b1;
    tick(3);
    sdaLow = 1'b1;
    tick(3);
    sclPin = 1'b0;
  endtask : start

  task automatic stop;
    tick(3);
    sdaLow = 1'b1;
    tick(3);
    sclPin = 1'b1;
    tick(3);
    sdaLow = 1'b0;
    tick(3);
  endtask : stop

  // Ack returned as sampled: 0 means acknowledged
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, ack);
  endtask : wbyte

  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~more, r);
  endtask : rbyte
endmodule : sew_ctl_model

// [tb/testbench.sv]
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/10ps
`include "sew_defines.svh"
module testbench;
  import sew_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic core_clk, sys_rst, sclPin, sdaLow, sdaLine, sdaOut, sdaOe, programBusy;
  logic chipSelectBit0 = 1'b1;
  logic chipSelectBit1 = 1'bz;
  logic chipSelectBit2 = 1'b1;
  logic writeProtect = 1'b0;
  int errors = 0;
  int compares = 0;
  // Pull-up on the shared data line
  assign sdaLine = sdaLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  sew_slave #(.PROG_CYCLES(200)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .sclPin(sclPin), .sdaIn(sdaLine), .chipSelectBit0(chipSelectBit0),
    .chipSelectBit1(chipSelectBit1), .chipSelectBit2(chipSelectBit2),
    .writeProtect(writeProtect), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .programBusy(programBusy));
  sew_ctl_model i_ctl (.core_clk(core_clk), .sdaLine(sdaLine), .sclPin(sclPin),
    .sdaLow(sdaLow));

  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic devw(input logic rw, output logic a);
    i_ctl.start();
    i_ctl.wbyte({`SEW_DEV_TYPE, STRAP, rw}, a);
  endtask : devw

  task automatic point(input logic [14:0] ad);
    logic a;
    devw(1'b0, a);
    chk("dev ack", 8'h00, {7'h00, a});
    i_ctl.wbyte({1'b0, ad[14:8]}, a);
    chk("hi ack", 8'h00, {7'h00, a});
    i_ctl.wbyte(ad[7:0], a);
    chk("lo ack", 8'h00, {7'h00, a});
  endtask : point

  task automatic wr(input logic [14:0] ad, input logic [7:0] q[$]);
    logic a;
    point(ad);
    foreach (q[i]) begin
      i_ctl.wbyte(q[i], a);
      chk("data ack", 8'h00, {7'h00, a});
    end
    i_ctl.stop();
    i_ctl.tick(20);
  endtask : wr

  // Reads q.size() bytes, acking all but the last
  task automatic rd(input logic [14:0] ad, input logic [7:0] q[$]);
    logic a;
    logic [7:0] d;
    point(ad);
    devw(1'b1, a);
    chk("rd ack", 8'h00, {7'h00, a});
    foreach (q[i]) begin
      i_ctl.rbyte(i < q.size() - 1, d);
      chk("rd data", q[i], d);
    end
    i_ctl.stop();
  endtask : rd

  task automatic waitIdle;
    int n;
    n = 0;
    while (programBusy !== 1'b0 && n < 400) begin
      i_ctl.tick(1);
      n++;
    end
    if (n == 400) begin
      errors++;
      close_out();
    end
  endtask : waitIdle

  task automatic t_select;
    logic a;
    logic [7:0] bad[3] = '{{4'h5, STRAP, 1'b0}, {4'hA, 3'h7, 1'b0}, {4'hA, 3'h4, 1'b0}};
    chk("idle oe", 8'h00, {7'h00, sdaOe});
    chk("sda out", 8'h00, {7'h00, sdaOut});
    foreach (bad[i]) begin
      i_ctl.start();
      i_ctl.wbyte(bad[i], a);
      chk("no ack", 8'h01, {7'h00, a});
      i_ctl.stop();
    end
  endtask : t_select

  task automatic t_byte;
    logic a;
    logic [7:0] d;
    wr(15'h1234, '{8'h5A});
    chk("busy", 8'h01, {7'h00, programBusy});
    devw(1'b0, a);
    chk("poll busy", 8'h01, {7'h00, a});
    i_ctl.stop();
    waitIdle();
    devw(1'b1, a);
    chk("poll done", 8'h00, {7'h00, a});
    i_ctl.rbyte(1'b0, d);
    i_ctl.stop();
    rd(15'h1234, '{8'h5A});
  endtask : t_byte

  task automatic t_page;
    logic a;
    logic [7:0] d;
    wr(15'h0A3E, '{8'h11, 8'h22, 8'h33, 8'h44});
    chk("busy", 8'h01, {7'h00, programBusy});
    waitIdle();
    rd(15'h0A3E, '{8'h11, 8'h22});
    rd(15'h0A00, '{8'h33});
    devw(1'b1, a);
    i_ctl.rbyte(1'b0, d);
    chk("current", 8'h44, d);
    i_ctl.stop();
  endtask : t_page

  task automatic t_protect;
    writeProtect = 1'b1;
    wr(15'h0A00, '{8'hEE});
    waitIdle();
    writeProtect = 1'b0;
    rd(15'h0A00, '{8'h33});
  endtask : t_protect

  task automatic t_wrap;
    wr(15'h7FFF, '{8'h77});
    waitIdle();
    wr(15'h0000, '{8'h66});
    waitIdle();
    rd(15'h7FFF, '{8'h77, 8'h66});
  endtask : t_wrap

  initial begin
    sys_rst = 1'b1;
    i_ctl.tick(2);
    chk("rst busy", 8'h00, {7'h00, programBusy});
    sys_rst = 1'b0;
    i_ctl.tick(3);
    t_select();
    t_byte();
    t_page();
    t_protect();
    t_wrap();
    close_out();
  end
endmodule : testbench
